// [core/scr_out_divider.sv]
/*
 * scr_out_divider: 8-bit lvcmos output divider counting pre-divider ticks,
 * output high for the first half of each period.
 * Assumes i_tick is a one-cycle pulse and i_code the software ratio code.
 */
`timescale 1ns/10ps
`default_nettype none

module scr_out_divider (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_arst_n,
	// source and setting
	input  wire logic       i_tick,
	input  wire logic [7:0] i_code,
	// divided clock level
	output logic            o_clk
);
	import scr_pkg::*;

	logic [8:0] ratio;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	always_comb begin
		ratio    = scr_div_ratio(i_code);
		cnt_next = cnt_reg;
		if (ratio == 9'h000) begin
			cnt_next = 8'h00;
		end else if (i_tick) begin
			// a shrunken ratio wraps at once instead of running to 255
			if ({1'b0, cnt_reg} >= ratio - 9'h001) begin
				cnt_next = 8'h00;
			end else begin
				cnt_next = cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg <= 8'h00;
			o_clk   <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			o_clk   <= (ratio != 9'h000) && ({1'b0, cnt_next} < (ratio >> 1));
		end
	end

	AST_DIV_STEADY_NO_TICK: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(!i_tick && $stable(i_code)) |=> $stable(o_clk))
		else $error("divider output moved without a tick");

	AST_DIV_STOPPED_LOW: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_code == 8'h00) |=> !o_clk)
		else $error("stopped divider output not low");

endmodule : scr_out_divider

`default_nettype wire

// [core/scr_pkg.sv]
/*
 * scr_pkg: register indices, field positions, reset values, select encodings
 * and shared decode functions for the status pin clock route block.
 * Assumes a single 20 MHz system clock and byte addresses of four times the index.
 */
package scr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0]  SCR_IDX_ROUTE_CTRL = 8'h2d;
	localparam logic [7:0]  SCR_IDX_DIV_A      = 8'h2e;
	localparam logic [7:0]  SCR_IDX_DIV_B      = 8'h2f;
	localparam logic [7:0]  SCR_IDX_PIN_STATE  = 8'h30;

	// reset values
	localparam logic [7:0]  SCR_ROUTE_CTRL_RST = 8'h0a;
	localparam logic [7:0]  SCR_DIV_A_RST      = 8'h00;
	localparam logic [7:0]  SCR_DIV_B_RST      = 8'h00;

	// field positions inside the route control register
	localparam int unsigned SCR_PRE_B_LSB      = 6;
	localparam int unsigned SCR_PRE_A_LSB      = 4;
	localparam int unsigned SCR_SRC_B_LSB      = 2;
	localparam int unsigned SCR_SRC_A_LSB      = 0;

	// pin state register bit positions
	localparam int unsigned SCR_ST_PIN_A       = 0;
	localparam int unsigned SCR_ST_PIN_B       = 1;
	localparam int unsigned SCR_ST_DIV_A       = 2;
	localparam int unsigned SCR_ST_DIV_B       = 3;

	// division figures
	localparam logic [2:0]  SCR_PRE_N4         = 3'h4;
	localparam logic [2:0]  SCR_PRE_N5         = 3'h5;
	localparam logic [7:0]  SCR_DIV_SHORT_MAX  = 8'h05;
	localparam logic [8:0]  SCR_DIV_MIN_RATIO  = 9'h006;

	typedef enum logic [1:0] {
		SCR_PRE_OFF,
		SCR_PRE_DIV4,
		SCR_PRE_DIV5,
		SCR_PRE_RSVD
	} scr_pre_sel_t;

	typedef enum logic [1:0] {
		SCR_SRC_DIV_A,
		SCR_SRC_DIV_B,
		SCR_SRC_STATUS,
		SCR_SRC_OFF
	} scr_src_sel_t;

	typedef enum logic [0:0] {
		SCR_BUS_IDLE,
		SCR_BUS_ACK
	} scr_bus_state_t;

	// two-bit field of the route control register
	function automatic logic [1:0] scr_field(input logic [7:0] ctrl, input int unsigned lsb);
		scr_field = ctrl[lsb +: 2];
	endfunction : scr_field

	// output divider ratio; zero means stopped
	function automatic logic [8:0] scr_div_ratio(input logic [7:0] code);
		if (code == 8'h00) begin
			scr_div_ratio = 9'h000;
		end else if (code <= SCR_DIV_SHORT_MAX) begin
			scr_div_ratio = SCR_DIV_MIN_RATIO;
		end else begin
			scr_div_ratio = {1'b0, code} + 9'h001;
		end
	endfunction : scr_div_ratio

	// pre-divider ratio; zero means stopped, reserved code stops too
	function automatic logic [2:0] scr_pre_ratio(input scr_pre_sel_t sel);
		if (sel == SCR_PRE_DIV4) begin
			scr_pre_ratio = SCR_PRE_N4;
		end else if (sel == SCR_PRE_DIV5) begin
			scr_pre_ratio = SCR_PRE_N5;
		end else begin
			scr_pre_ratio = 3'h0;
		end
	endfunction : scr_pre_ratio

endpackage : scr_pkg

// [core/scr_prescale.sv]
/*
 * scr_prescale: lvcmos pre-divider, emits one tick every four or five
 * source edges, or none while stopped.
 * Assumes i_src_edge is a one-cycle pulse per rising edge of the pll clock.
 */
`timescale 1ns/10ps
`default_nettype none

module scr_prescale (
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_arst_n,
	// source and setting
	input  wire logic                  i_src_edge,
	input  wire scr_pkg::scr_pre_sel_t i_sel,
	// divided tick
	output logic                       o_tick
);
	import scr_pkg::*;

	logic [2:0] ratio;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic       tick_next;

	always_comb begin
		ratio     = scr_pre_ratio(i_sel);
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (ratio == 3'h0) begin
			cnt_next = 3'h0;
		end else if (i_src_edge) begin
			if (cnt_reg >= ratio - 3'h1) begin
				cnt_next  = 3'h0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg <= 3'h0;
			o_tick  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			o_tick  <= tick_next;
		end
	end

	COV_PRE_DIV5_TICK: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		(i_sel == SCR_PRE_DIV5) && o_tick);

endmodule : scr_prescale

`default_nettype wire

// [core/scr_route.sv]
/*
 * scr_route: status pin lvcmos clock route. Holds the route control and the
 * two output divider registers behind an Avalon-MM slave, runs the two
 * pre-dividers and output dividers, and muxes both status pins.
 * Assumes pll clocks and the normal status levels are synchronous inputs,
 * each pll clock high or low for at least one system clock.
 */
`timescale 1ns/10ps
`default_nettype none

// How it works
// - each status pin can carry divider a's or divider b's clock.
// - the output dividers are fed by the first or second pll pre-divider.
// - bits 7:6 set second pre-divider: off, by 4, by 5, reserved; reset off.
// - bits 5:4 set first pre-divider: off, by 4, by 5, reserved; reset off.
// - bits 3:2 pick second pin: divider a, divider b, status, off; reset status.
// - bits 1:0 pick first pin: divider a, divider b, status, off; reset status.
// - divider a is 8-bit and counts the first pre-divider's output.
// - divider b is 8-bit and counts the second pre-divider's output.
// - ratio code 0 stops, 1 to 5 divide by 6, n divides by n+1.
module scr_route (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_arst_n,
	// avalon-mm slave
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// pll clocks and normal status levels
	input  wire logic        i_first_pll_clk,
	input  wire logic        i_second_pll_clk,
	input  wire logic        i_first_status,
	input  wire logic        i_second_status,
	// status pins
	output logic             o_first_status_pin,
	output logic             o_second_status_pin
);
	import scr_pkg::*;

	scr_bus_state_t bus_state_reg;
	logic [7:0]     cmos_clock_route_control_reg;
	logic [7:0]     lvcmos_out_divider_a_reg;
	logic [7:0]     lvcmos_out_divider_b_reg;
	logic [7:0]     word_index;
	logic           bus_req;
	logic           bus_take;
	logic           wr_lane0;
	logic [31:0]    readdata_next;
	logic           first_pll_prev_reg;
	logic           second_pll_prev_reg;
	logic           first_pll_edge;
	logic           second_pll_edge;
	scr_pre_sel_t   first_pll_lvcmos_prescale_sel;
	scr_pre_sel_t   second_pll_lvcmos_prescale_sel;
	scr_src_sel_t   first_status_pin_source_sel;
	scr_src_sel_t   second_status_pin_source_sel;
	logic           tick_a;
	logic           tick_b;
	logic           div_a_clk;
	logic           div_b_clk;
	logic [7:0]     div_a_code;
	logic [7:0]     div_b_code;

	// pin level for a given source selection
	function automatic logic pin_level(input scr_src_sel_t sel, input logic a, input logic b,
		input logic status);
		if (sel == SCR_SRC_DIV_A) begin
			pin_level = a;
		end else if (sel == SCR_SRC_DIV_B) begin
			pin_level = b;
		end else if (sel == SCR_SRC_STATUS) begin
			pin_level = status;
		end else begin
			pin_level = 1'b0;
		end
	endfunction : pin_level

	// code as seen by an output divider; a stopped pre-divider stops the divider too
	function automatic logic [7:0] fed_code(input scr_pre_sel_t sel, input logic [7:0] code);
		if (scr_pre_ratio(sel) == 3'h0) begin
			fed_code = 8'h00;
		end else begin
			fed_code = code;
		end
	endfunction : fed_code

	// ---------------- avalon-mm slave ----------------
	// every access answers after one wait cycle: waitrequest low on the second edge
	assign bus_req    = i_avs_read || i_avs_write;
	assign bus_take   = bus_req && (bus_state_reg == SCR_BUS_ACK);
	assign wr_lane0   = i_avs_write && bus_take && i_avs_byteenable[0];
	assign word_index = {2'h0, i_avs_address[7:2]};

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_state_reg     <= SCR_BUS_IDLE;
			o_avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state_reg)
				SCR_BUS_IDLE: begin
					if (bus_req) begin
						bus_state_reg     <= SCR_BUS_ACK;
						o_avs_waitrequest <= 1'b0;
					end
				end
				default: begin
					bus_state_reg     <= SCR_BUS_IDLE;
					o_avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// read data set up while waitrequest falls, held until the next read
	always_comb begin
		readdata_next = 32'h0000_0000;
		if (word_index == SCR_IDX_ROUTE_CTRL) begin
			readdata_next[7:0] = cmos_clock_route_control_reg;
		end else if (word_index == SCR_IDX_DIV_A) begin
			readdata_next[7:0] = lvcmos_out_divider_a_reg;
		end else if (word_index == SCR_IDX_DIV_B) begin
			readdata_next[7:0] = lvcmos_out_divider_b_reg;
		end else if (word_index == SCR_IDX_PIN_STATE) begin
			readdata_next[SCR_ST_PIN_A] = o_first_status_pin;
			readdata_next[SCR_ST_PIN_B] = o_second_status_pin;
			readdata_next[SCR_ST_DIV_A] = div_a_clk;
			readdata_next[SCR_ST_DIV_B] = div_b_clk;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && (bus_state_reg == SCR_BUS_IDLE)) begin
			o_avs_readdata <= readdata_next;
		end
	end

	// ---------------- registers ----------------
	// writes land at the edge where waitrequest is seen low; unmapped ones are dropped
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmos_clock_route_control_reg <= SCR_ROUTE_CTRL_RST;
		end else if (wr_lane0 && (word_index == SCR_IDX_ROUTE_CTRL)) begin
			cmos_clock_route_control_reg <= i_avs_writedata[7:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lvcmos_out_divider_a_reg <= SCR_DIV_A_RST;
		end else if (wr_lane0 && (word_index == SCR_IDX_DIV_A)) begin
			lvcmos_out_divider_a_reg <= i_avs_writedata[7:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lvcmos_out_divider_b_reg <= SCR_DIV_B_RST;
		end else if (wr_lane0 && (word_index == SCR_IDX_DIV_B)) begin
			lvcmos_out_divider_b_reg <= i_avs_writedata[7:0];
		end
	end

	// field decode
	assign second_pll_lvcmos_prescale_sel = scr_pre_sel_t'(scr_field(cmos_clock_route_control_reg,
		SCR_PRE_B_LSB));
	assign first_pll_lvcmos_prescale_sel  = scr_pre_sel_t'(scr_field(cmos_clock_route_control_reg,
		SCR_PRE_A_LSB));
	assign second_status_pin_source_sel   = scr_src_sel_t'(scr_field(cmos_clock_route_control_reg,
		SCR_SRC_B_LSB));
	assign first_status_pin_source_sel    = scr_src_sel_t'(scr_field(cmos_clock_route_control_reg,
		SCR_SRC_A_LSB));

	// ---------------- clock path ----------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			first_pll_prev_reg  <= 1'b0;
			second_pll_prev_reg <= 1'b0;
		end else begin
			first_pll_prev_reg  <= i_first_pll_clk;
			second_pll_prev_reg <= i_second_pll_clk;
		end
	end

	assign first_pll_edge  = i_first_pll_clk && !first_pll_prev_reg;
	assign second_pll_edge = i_second_pll_clk && !second_pll_prev_reg;

	// first pll pre-divider feeds divider a, second feeds divider b
	scr_prescale u_prescale_a (
		.i_clock    (i_clock),
		.i_arst_n   (i_arst_n),
		.i_src_edge (first_pll_edge),
		.i_sel      (first_pll_lvcmos_prescale_sel),
		.o_tick     (tick_a)
	);

	scr_prescale u_prescale_b (
		.i_clock    (i_clock),
		.i_arst_n   (i_arst_n),
		.i_src_edge (second_pll_edge),
		.i_sel      (second_pll_lvcmos_prescale_sel),
		.o_tick     (tick_b)
	);

	// a divider with no source restarts low instead of freezing mid-period
	assign div_a_code = fed_code(first_pll_lvcmos_prescale_sel, lvcmos_out_divider_a_reg);
	assign div_b_code = fed_code(second_pll_lvcmos_prescale_sel, lvcmos_out_divider_b_reg);

	scr_out_divider u_divider_a (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_tick   (tick_a),
		.i_code   (div_a_code),
		.o_clk    (div_a_clk)
	);

	scr_out_divider u_divider_b (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_tick   (tick_b),
		.i_code   (div_b_code),
		.o_clk    (div_b_clk)
	);

	// ---------------- status pins ----------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_first_status_pin  <= 1'b0;
			o_second_status_pin <= 1'b0;
		end else begin
			o_first_status_pin  <= pin_level(first_status_pin_source_sel, div_a_clk, div_b_clk,
				i_first_status);
			o_second_status_pin <= pin_level(second_status_pin_source_sel, div_a_clk, div_b_clk,
				i_second_status);
		end
	end

	// ---------------- checks ----------------
	AST_FIRST_PIN_FROM_DIV: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(first_status_pin_source_sel == SCR_SRC_DIV_B) |=> (o_first_status_pin == $past(div_b_clk)))
		else $error("first pin does not follow divider b");

	AST_SECOND_PIN_FROM_DIV: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(second_status_pin_source_sel == SCR_SRC_DIV_A) |=> (o_second_status_pin == $past(div_a_clk)))
		else $error("second pin does not follow divider a");

	AST_SECOND_PIN_STATUS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(second_status_pin_source_sel == SCR_SRC_STATUS) |=> (o_second_status_pin == $past(i_second_status)))
		else $error("second pin does not carry normal status");

	AST_FIRST_PIN_STATUS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(first_status_pin_source_sel == SCR_SRC_STATUS) |=> (o_first_status_pin == $past(i_first_status)))
		else $error("first pin does not carry normal status");

	AST_PRE_B_OFF_DIV_LOW: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		((second_pll_lvcmos_prescale_sel == SCR_PRE_OFF) || (second_pll_lvcmos_prescale_sel == SCR_PRE_RSVD))
		|=> !div_b_clk)
		else $error("divider b runs while its pre-divider is off");

	AST_PIN_OFF_LOW: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(first_status_pin_source_sel == SCR_SRC_OFF) |=> !o_first_status_pin)
		else $error("disabled first pin not low");

	AST_PRE_B_OFF_SILENT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		((second_pll_lvcmos_prescale_sel == SCR_PRE_OFF) || (second_pll_lvcmos_prescale_sel == SCR_PRE_RSVD))
		|=> !tick_b)
		else $error("second pre-divider ticks while off");

	AST_PRE_A_OFF_SILENT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(first_pll_lvcmos_prescale_sel == SCR_PRE_OFF) [*2] |=> (!tick_a && !div_a_clk))
		else $error("first pre-divider ticks while off");

	AST_PRE_A_DIV4_GAP: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(tick_a && (first_pll_lvcmos_prescale_sel == SCR_PRE_DIV4) && $stable(first_pll_lvcmos_prescale_sel))
		|=> !tick_a [*6])
		else $error("first pre-divider ticked sooner than four pll edges");

	AST_DIV_B_NEEDS_TICK: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		($rose(div_b_clk) && ($past(div_b_code) == $past(div_b_code, 2))) |-> $past(tick_b))
		else $error("divider b moved without a second pre-divider tick");

	AST_BUS_ONE_WAIT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
		(bus_req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not after exactly one wait cycle");

	COV_FIRST_PIN_DIV_A: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		(first_status_pin_source_sel == SCR_SRC_DIV_A) && $rose(o_first_status_pin));

	COV_SECOND_PIN_DIV_B: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		(second_status_pin_source_sel == SCR_SRC_DIV_B) && $rose(o_second_status_pin));

	COV_CTRL_WRITE: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		wr_lane0 && (word_index == SCR_IDX_ROUTE_CTRL));

	COV_PIN_STATUS_READ: cover property (@(posedge i_clock) disable iff (!i_arst_n)
		i_avs_read && bus_take && (word_index == SCR_IDX_PIN_STATE));

endmodule : scr_route

`default_nettype wire

// [dv/scr_route_test.sv]
/*
 * scr_route_test: self-checking bench for the status pin clock route block.
 * Assumes a single 50 ns system clock, free running pll clocks made here,
 * and registers at four times their word index over avalon-mm.
 */
`timescale 1ns/10ps
`default_nettype none

module scr_route_test;
	import scr_pkg::*;

	localparam logic [7:0] A_CTRL  = {SCR_IDX_ROUTE_CTRL[5:0], 2'b00};
	localparam logic [7:0] A_DIVA  = {SCR_IDX_DIV_A[5:0], 2'b00};
	localparam logic [7:0] A_DIVB  = {SCR_IDX_DIV_B[5:0], 2'b00};
	localparam logic [7:0] A_STATE = {SCR_IDX_PIN_STATE[5:0], 2'b00};
	localparam logic [7:0] A_NONE  = 8'hf0;

	logic        i_clock;
	logic        i_arst_n;
	logic [7:0]  i_avs_address;
	logic        i_avs_read;
	logic        i_avs_write;
	logic [31:0] i_avs_writedata;
	logic [3:0]  i_avs_byteenable;
	logic [31:0] o_avs_readdata;
	logic        o_avs_waitrequest;
	logic        i_first_pll_clk;
	logic        i_second_pll_clk;
	logic        i_first_status;
	logic        i_second_status;
	logic        o_first_status_pin;
	logic        o_second_status_pin;
	logic        pll_b_half;
	int          errors;
	int          total_checks;
	logic [31:0] rd_q[$];

	scr_route DUT (
		.i_clock             (i_clock),
		.i_arst_n            (i_arst_n),
		.i_avs_address       (i_avs_address),
		.i_avs_read          (i_avs_read),
		.i_avs_write         (i_avs_write),
		.i_avs_writedata     (i_avs_writedata),
		.i_avs_byteenable    (i_avs_byteenable),
		.o_avs_readdata      (o_avs_readdata),
		.o_avs_waitrequest   (o_avs_waitrequest),
		.i_first_pll_clk     (i_first_pll_clk),
		.i_second_pll_clk    (i_second_pll_clk),
		.i_first_status      (i_first_status),
		.i_second_status     (i_second_status),
		.o_first_status_pin  (o_first_status_pin),
		.o_second_status_pin (o_second_status_pin)
	);

	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end

	// first pll period is 2 system cycles, second pll period is 4
	always @(posedge i_clock) begin
		i_first_pll_clk <= ~i_first_pll_clk;
		pll_b_half      <= ~pll_b_half;
		if (pll_b_half) begin
			i_second_pll_clk <= ~i_second_pll_clk;
		end
	end

	task automatic stop_test();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// waits for waitrequest low, request held until that edge
	task automatic bus_wait();
		int n;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			errors++;
			stop_test();
		end
	endtask : bus_wait

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic be);
		@(posedge i_clock);
		i_avs_address    <= a;
		i_avs_writedata  <= {24'h000000, d};
		i_avs_byteenable <= {3'b000, be};
		i_avs_write      <= 1'b1;
		bus_wait();
		i_avs_write <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		rd_q.push_back({24'h000000, exp});
		i_avs_address <= a;
		i_avs_read    <= 1'b1;
		bus_wait();
		i_avs_read <= 1'b0;
	endtask : bus_read

	// read results are matched against the oldest note
	always @(posedge i_clock) begin
		if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
			if (rd_q.size() == 0) begin
				errors++;
			end else begin
				check("readdata", o_avs_readdata, rd_q.pop_front());
			end
		end
	end

	function automatic logic pin_val(input logic pin_b);
		pin_val = pin_b ? o_second_status_pin : o_first_status_pin;
	endfunction : pin_val

	task automatic wait_level(input logic pin_b, input logic lvl, output int n);
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (pin_val(pin_b) !== lvl && n < 5000);
		if (n >= 5000) begin
			errors++;
			stop_test();
		end
	endtask : wait_level

	// expected pin waveform worked out from the control byte and codes
	task automatic run_case(input logic [7:0] ctrl, input logic [7:0] ca, input logic [7:0] cb, input logic pin_b);
		logic [1:0] src;
		logic [1:0] pre;
		logic [7:0] code;
		int         m;
		int         pn;
		int         r;
		int         hi;
		int         lo;
		src  = pin_b ? ctrl[3:2] : ctrl[1:0];
		pre  = src[0] ? ctrl[7:6] : ctrl[5:4];
		code = src[0] ? cb : ca;
		m    = src[0] ? 4 : 2;
		pn   = (pre == 2'h1) ? 4 : (pre == 2'h2) ? 5 : 0;
		r    = (code == 8'h00) ? 0 : (code < 8'h06) ? 6 : int'(code) + 1;
		bus_write(A_DIVA, ca, 1'b1);
		bus_write(A_DIVB, cb, 1'b1);
		bus_write(A_CTRL, ctrl, 1'b1);
		// let the old routing and any restart glitch pass before watching the pin
		repeat (3) @(posedge i_clock);
		if (pn == 0 || r == 0) begin
			hi = 0;
			repeat (300) begin
				@(posedge i_clock);
				if (pin_val(pin_b) !== 1'b0) begin
					hi++;
				end
			end
			check("stopped pin high cycles", hi, 0);
		end else begin
			wait_level(pin_b, 1'b1, hi);
			wait_level(pin_b, 1'b0, hi);
			wait_level(pin_b, 1'b1, hi);
			wait_level(pin_b, 1'b0, hi);
			wait_level(pin_b, 1'b1, lo);
			check("pin high cycles", hi, (r / 2) * pn * m);
			check("pin period", hi + lo, r * pn * m);
		end
	endtask : run_case

	logic [7:0] t_ctrl[8] = '{8'h94, 8'h94, 8'h61, 8'h61, 8'h94, 8'h94, 8'hc1, 8'hc1};
	logic [7:0] t_ca[8]   = '{8'h01, 8'h01, 8'h06, 8'h06, 8'hff, 8'h00, 8'h07, 8'h07};
	logic [7:0] t_cb[8]   = '{8'h05, 8'h05, 8'h07, 8'h07, 8'h05, 8'h05, 8'h07, 8'h07};
	logic       t_pin[8]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

	initial begin
		logic [31:0] r;
		i_arst_n = 1'b0;
		i_avs_address = 8'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h00000000;
		i_avs_byteenable = 4'h0;
		i_first_pll_clk = 1'b0;
		i_second_pll_clk = 1'b0;
		pll_b_half = 1'b0;
		i_first_status = 1'b0;
		i_second_status = 1'b0;
		errors = 0;
		total_checks = 0;
		void'($urandom(93));
		repeat (3) @(posedge i_clock);
		i_arst_n <= 1'b1;
		bus_read(A_CTRL, 8'h0a);
		bus_read(A_DIVA, 8'h00);
		bus_read(A_DIVB, 8'h00);
		bus_read(A_NONE, 8'h00);
		// normal status follows the inputs one cycle late
		repeat (8) begin
			r = $urandom;
			i_first_status  <= r[0];
			i_second_status <= r[1];
			@(posedge i_clock);
			@(posedge i_clock);
			check("first pin status", o_first_status_pin, r[0]);
			check("second pin status", o_second_status_pin, r[1]);
		end
		i_first_status  <= 1'b1;
		i_second_status <= 1'b1;
		bus_read(A_STATE, 8'h03);
		bus_write(A_CTRL, 8'h0f, 1'b1);
		repeat (3) @(posedge i_clock);
		check("first pin off", o_first_status_pin, 1'b0);
		check("second pin off", o_second_status_pin, 1'b0);
		bus_write(A_STATE, 8'hff, 1'b1);
		bus_read(A_STATE, 8'h00);
		// register access: read back, byte lane off, unmapped place
		r = $urandom;
		bus_write(A_CTRL, r[7:0], 1'b1);
		bus_read(A_CTRL, r[7:0]);
		bus_write(A_CTRL, ~r[7:0], 1'b0);
		bus_read(A_CTRL, r[7:0]);
		bus_write(A_DIVB, r[15:8], 1'b1);
		bus_read(A_DIVB, r[15:8]);
		bus_write(A_NONE, 8'hff, 1'b1);
		bus_read(A_NONE, 8'h00);
		// divided clocks, routing and stopped cases
		for (int i = 0; i < 8; i++) begin
			run_case(t_ctrl[i], t_ca[i], t_cb[i], t_pin[i]);
		end
		r = 6 + ($urandom % 50);
		run_case(8'h94, r[7:0], 8'h05, 1'b0);
		stop_test();
	end

endmodule : scr_route_test

`default_nettype wire
